/* verilog/lfa_pkg.sv */
// constants, command codes and state layout for the literal/file alu block
package lfa_pkg;

	// ********************************************************
	// register map (byte addresses, one word each)
	// ********************************************************
	localparam logic [11:0] OFF_ACC = 12'h000;
	localparam logic [11:0] OFF_STATUS = 12'h004;
	localparam logic [11:0] OFF_PTR0 = 12'h008;
	localparam logic [11:0] OFF_PTR1 = 12'h00C;
	localparam logic [11:0] OFF_CMD = 12'h010;
	localparam logic [11:0] OFF_INFO = 12'h014;
	localparam logic [11:0] OFF_CYCLES = 12'h018;
	// file registers 0..127 at FILE_BASE + 4*f
	localparam logic [11:0] FILE_BASE = 12'h200;
	localparam int FILE_DEPTH = 128;

	// ********************************************************
	// field positions
	// ********************************************************
	localparam int ST_C_BIT = 0;
	localparam int ST_HALF_BYTE_BIT = 1;
	localparam int ST_Z_BIT = 2;
	localparam int CMD_LIT_LSB = 0;
	localparam int CMD_FILE_LSB = 8;
	localparam int CMD_DEST_BIT = 15;
	localparam int CMD_PSEL_BIT = 16;
	localparam int CMD_OP_LSB = 17;
	localparam int CMD_PC_BIT = 20;
	localparam int CMD_COND_BIT = 21;
	localparam int CMD_W = 22;
	localparam int INFO_BUSY_BIT = 0;
	localparam int INFO_LAST_LSB = 8;
	localparam int PTR_TOP_BIT = 15;

	// file addresses that act as windows through a pointer
	localparam logic [6:0] WIN0_ADDR = 7'h00;
	localparam logic [6:0] WIN1_ADDR = 7'h01;

	// ********************************************************
	// reset values
	// ********************************************************
	localparam logic [7:0] ACC_RST = 8'h00;
	localparam logic [15:0] PTR_RST = 16'h0000;
	localparam logic [31:0] CYC_RST = 32'h0000_0000;

	// ********************************************************
	// types
	// ********************************************************
	typedef enum logic [2:0] {
		OP_AND_LIT = 3'h0,
		OP_ADD_LIT = 3'h1,
		OP_AND_FILE = 3'h2,
		OP_ADD_FILE = 3'h3,
		OP_ASR_FILE = 3'h4,
		OP_PTR_ADD = 3'h5,
		OP_NOP6 = 3'h6,
		OP_NOP7 = 3'h7
	} lfa_op_e;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_FETCH = 4'h2,
		ST_EXEC = 4'h4,
		ST_STALL = 4'h8
	} lfa_state_e;

	typedef struct packed {
		lfa_state_e st;
		logic [7:0] acc;
		logic c;
		logic half_byte_out_flag;
		logic z;
		logic [15:0] ptr0;
		logic [15:0] ptr1;
		logic [CMD_W-1:0] cmd;
		logic [1:0] extra;
		logic [1:0] last_cyc;
		logic [31:0] cyc_total;
		logic busy;
		logic [11:0] haddr;
		logic hwrite;
		logic [1:0] ph;
		logic [31:0] hrdata;
		logic hreadyout;
		logic hresp;
	} lfa_state_s;

	typedef struct packed {
		logic [7:0] res;
		logic c;
		logic half_byte_out_flag;
		logic z;
		logic [15:0] ptr;
	} lfa_alu_out_s;

endpackage

/* verilog/lfa_file_mem.sv */
// 128 x 8 file register store, registered read data
`timescale 1ns/1ps
module lfa_file_mem (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic we,
	input wire logic [6:0] waddr,
	input wire logic [7:0] wdata,
	input wire logic [6:0] raddr,
	output logic [7:0] rdata
);
	logic [7:0] mem [0:lfa_pkg::FILE_DEPTH-1];

	always_ff @(posedge hclk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rdata <= 8'h00;
		end else begin
			rdata <= mem[raddr];
		end
	end
endmodule

/* verilog/lfa_alu.sv */
// combinational datapath: and, add, arithmetic shift, pointer add
`timescale 1ns/1ps
module lfa_alu (
	input wire lfa_pkg::lfa_op_e op,
	input wire logic [7:0] acc,
	input wire logic [7:0] opnd,
	input wire logic [5:0] lit6,
	input wire logic [15:0] ptr_in,
	output lfa_pkg::lfa_alu_out_s y
);
	logic [8:0] sum9;
	logic [4:0] sum5;

	always_comb begin
		sum9 = {1'b0, acc} + {1'b0, opnd};
		sum5 = {1'b0, acc[3:0]} + {1'b0, opnd[3:0]};
		y.res = 8'h00;
		y.c = sum9[8];
		y.half_byte_out_flag = sum5[4];
		// 16-bit sum drops the carry, so the pointer wraps
		y.ptr = ptr_in + {{10{lit6[5]}}, lit6};
		unique case (op)
			lfa_pkg::OP_AND_LIT, lfa_pkg::OP_AND_FILE: begin
				y.res = acc & opnd;
			end
			lfa_pkg::OP_ADD_LIT, lfa_pkg::OP_ADD_FILE: begin
				y.res = sum9[7:0];
			end
			lfa_pkg::OP_ASR_FILE: begin
				y.res = {opnd[7], opnd[7:1]};
				y.c = opnd[0];
			end
			lfa_pkg::OP_PTR_ADD, lfa_pkg::OP_NOP6, lfa_pkg::OP_NOP7: begin
				y.res = acc;
			end
		endcase
		y.z = (y.res == 8'h00);
	end
endmodule

/* verilog/lfa_core.sv */
// literal/file alu execution block with ahb-lite register slave
//
// Behaviour
// - pc change or true test adds one nop
// - window access, pointer top bit: one extra
// - pointer add: sign-extended 6-bit literal, flags kept
// - 16-bit pointer wraps at both ends
// - and literal into acc, zero flag only
// - add literal into acc, c half-carry z
// - and acc with file, zero flag only
// - add acc with file, c half-carry z
// - dest 0 to acc, 1 to file
// - shift right, bit 0 into carry
// - shift keeps bit 7
// - shift dest 0 acc, else file
//
// The register offsets and register access over AHB-Lite were left to the implementer.
`timescale 1ns/1ps
module lfa_core (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	output logic busy
);
	lfa_pkg::lfa_state_s s_r;
	lfa_pkg::lfa_state_s s_nxt;
	lfa_pkg::lfa_alu_out_s alu_y;
	lfa_pkg::lfa_op_e op;
	logic [7:0] lit;
	logic [6:0] fadr;
	logic dest_file;
	logic psel;
	logic win0;
	logic win1;
	logic [6:0] eff_addr;
	logic [7:0] opnd;
	logic [1:0] extra;
	logic mem_we;
	logic [6:0] mem_waddr;
	logic [7:0] mem_wdata;
	logic [6:0] mem_raddr;
	logic [7:0] mem_rdata;
	logic accept;
	logic in_file;
	logic can_go;
	logic [31:0] rd_val;

	// ********************************************************
	// command decode
	// ********************************************************
	always_comb begin
		op = lfa_pkg::lfa_op_e'(s_r.cmd[lfa_pkg::CMD_OP_LSB +: 3]);
		lit = s_r.cmd[lfa_pkg::CMD_LIT_LSB +: 8];
		fadr = s_r.cmd[lfa_pkg::CMD_FILE_LSB +: 7];
		dest_file = s_r.cmd[lfa_pkg::CMD_DEST_BIT];
		psel = s_r.cmd[lfa_pkg::CMD_PSEL_BIT];
		win0 = (fadr == lfa_pkg::WIN0_ADDR);
		win1 = (fadr == lfa_pkg::WIN1_ADDR);
		// a window reaches the file through its pointer's low bits
		eff_addr = win0 ? s_r.ptr0[6:0] : (win1 ? s_r.ptr1[6:0] : fadr);
		extra = 2'h0;
		// a taken test and a slow window stack: two at most
		if (s_r.cmd[lfa_pkg::CMD_PC_BIT] || s_r.cmd[lfa_pkg::CMD_COND_BIT]) begin
			extra = 2'h1;
		end
		if ((op == lfa_pkg::OP_AND_FILE || op == lfa_pkg::OP_ADD_FILE ||
			op == lfa_pkg::OP_ASR_FILE) &&
			((win0 && s_r.ptr0[lfa_pkg::PTR_TOP_BIT]) ||
			(win1 && s_r.ptr1[lfa_pkg::PTR_TOP_BIT]))) begin
			extra = extra + 2'h1;
		end
		unique case (op)
			lfa_pkg::OP_AND_LIT, lfa_pkg::OP_ADD_LIT: begin
				opnd = lit;
			end
			default: begin
				opnd = mem_rdata;
			end
		endcase
	end

	lfa_alu u_alu (
		.op(op),
		.acc(s_r.acc),
		.opnd(opnd),
		.lit6(lit[5:0]),
		.ptr_in(psel ? s_r.ptr1 : s_r.ptr0),
		.y(alu_y)
	);

	lfa_file_mem u_mem (
		.hclk(hclk),
		.hresetn(hresetn),
		.we(mem_we),
		.waddr(mem_waddr),
		.wdata(mem_wdata),
		.raddr(mem_raddr),
		.rdata(mem_rdata)
	);

	// ********************************************************
	// read mux for the data phase
	// ********************************************************
	always_comb begin
		in_file = (s_r.haddr[11:9] == lfa_pkg::FILE_BASE[11:9]);
		// unused upper bits read as zero
		rd_val = 32'h0000_0000;
		if (in_file) begin
			rd_val = {24'h00_0000, mem_rdata};
		end else begin
			unique case (s_r.haddr)
				lfa_pkg::OFF_ACC: rd_val = {24'h00_0000, s_r.acc};
				lfa_pkg::OFF_STATUS: begin
					rd_val[lfa_pkg::ST_C_BIT] = s_r.c;
					rd_val[lfa_pkg::ST_HALF_BYTE_BIT] =
						s_r.half_byte_out_flag;
					rd_val[lfa_pkg::ST_Z_BIT] = s_r.z;
				end
				lfa_pkg::OFF_PTR0: rd_val = {16'h0000, s_r.ptr0};
				lfa_pkg::OFF_PTR1: rd_val = {16'h0000, s_r.ptr1};
				lfa_pkg::OFF_CMD: rd_val = {10'h000, s_r.cmd};
				lfa_pkg::OFF_INFO: begin
					rd_val[lfa_pkg::INFO_BUSY_BIT] = s_r.busy;
					rd_val[lfa_pkg::INFO_LAST_LSB +: 2] = s_r.last_cyc;
				end
				lfa_pkg::OFF_CYCLES: rd_val = s_r.cyc_total;
				default: rd_val = 32'h0000_0000;
			endcase
		end
	end

	// ********************************************************
	// next state
	// ********************************************************
	always_comb begin
		s_nxt = s_r;
		mem_we = 1'b0;
		mem_waddr = eff_addr;
		mem_wdata = alu_y.res;
		mem_raddr = (s_r.st == lfa_pkg::ST_FETCH) ? eff_addr : s_r.haddr[8:2];
		// narrow transfers are ignored without a wait
		accept = hsel && htrans[1] && hready && (hsize == 3'h2);
		// file store has one port pair; file accesses wait while the engine runs
		can_go = !in_file || (s_r.st == lfa_pkg::ST_IDLE);

		// engine
		unique case (s_r.st)
			lfa_pkg::ST_IDLE: begin
			end
			lfa_pkg::ST_FETCH: begin
				// operand read issued here lands next cycle
				s_nxt.st = lfa_pkg::ST_EXEC;
			end
			lfa_pkg::ST_EXEC: begin
				unique case (op)
					lfa_pkg::OP_AND_LIT: begin
						s_nxt.acc = alu_y.res;
						s_nxt.z = alu_y.z;
					end
					lfa_pkg::OP_ADD_LIT: begin
						s_nxt.acc = alu_y.res;
						s_nxt.c = alu_y.c;
						s_nxt.half_byte_out_flag =
							alu_y.half_byte_out_flag;
						s_nxt.z = alu_y.z;
					end
					lfa_pkg::OP_AND_FILE, lfa_pkg::OP_ADD_FILE,
					lfa_pkg::OP_ASR_FILE: begin
						if (dest_file) begin
							mem_we = 1'b1;
						end else begin
							s_nxt.acc = alu_y.res;
						end
						s_nxt.z = alu_y.z;
						if (op != lfa_pkg::OP_AND_FILE) begin
							s_nxt.c = alu_y.c;
						end
						if (op == lfa_pkg::OP_ADD_FILE) begin
							s_nxt.half_byte_out_flag =
								alu_y.half_byte_out_flag;
						end
					end
					lfa_pkg::OP_PTR_ADD: begin
						// status bits are left alone here
						if (psel) begin
							s_nxt.ptr1 = alu_y.ptr;
						end else begin
							s_nxt.ptr0 = alu_y.ptr;
						end
					end
					lfa_pkg::OP_NOP6, lfa_pkg::OP_NOP7: begin
					end
				endcase
				s_nxt.last_cyc = extra + 2'h1;
				s_nxt.cyc_total = s_r.cyc_total + {30'h0000_0000, extra} +
					32'h0000_0001;
				s_nxt.extra = extra;
				s_nxt.st = (extra == 2'h0) ? lfa_pkg::ST_IDLE : lfa_pkg::ST_STALL;
			end
			lfa_pkg::ST_STALL: begin
				// each stall cycle is an executed nop
				s_nxt.extra = s_r.extra - 2'h1;
				if (s_r.extra == 2'h1) begin
					s_nxt.st = lfa_pkg::ST_IDLE;
				end
			end
			default: begin
				s_nxt.st = lfa_pkg::ST_IDLE;
			end
		endcase

		// ********************************************************
		// bus slave
		// ********************************************************
		// bus slave: ph 1 = first data cycle, ph 2 = read collect
		if (s_r.ph == 2'h1 && can_go) begin
			if (s_r.hwrite) begin
				s_nxt.ph = 2'h0;
				s_nxt.hreadyout = 1'b1;
				if (in_file) begin
					mem_we = 1'b1;
					mem_waddr = s_r.haddr[8:2];
					mem_wdata = hwdata[7:0];
				end else begin
					unique case (s_r.haddr)
						lfa_pkg::OFF_ACC: s_nxt.acc = hwdata[7:0];
						lfa_pkg::OFF_STATUS: begin
							s_nxt.c = hwdata[lfa_pkg::ST_C_BIT];
							s_nxt.half_byte_out_flag =
								hwdata[lfa_pkg::ST_HALF_BYTE_BIT];
							s_nxt.z = hwdata[lfa_pkg::ST_Z_BIT];
						end
						lfa_pkg::OFF_PTR0: s_nxt.ptr0 = hwdata[15:0];
						lfa_pkg::OFF_PTR1: s_nxt.ptr1 = hwdata[15:0];
						lfa_pkg::OFF_CMD: begin
							// a command while busy is dropped
							if (s_r.st == lfa_pkg::ST_IDLE) begin
								s_nxt.cmd = hwdata[lfa_pkg::CMD_W-1:0];
								s_nxt.st = lfa_pkg::ST_FETCH;
							end
						end
						lfa_pkg::OFF_CYCLES: s_nxt.cyc_total = lfa_pkg::CYC_RST;
						default: begin
						end
					endcase
				end
			end else begin
				s_nxt.ph = 2'h2;
			end
		end else if (s_r.ph == 2'h2) begin
			s_nxt.hrdata = rd_val;
			s_nxt.ph = 2'h0;
			s_nxt.hreadyout = 1'b1;
		end
		if (accept) begin
			s_nxt.haddr = {haddr[11:2], 2'b00};
			s_nxt.hwrite = hwrite;
			s_nxt.ph = 2'h1;
			s_nxt.hreadyout = 1'b0;
		end
		s_nxt.hresp = 1'b0;
		s_nxt.busy = (s_nxt.st != lfa_pkg::ST_IDLE);
	end

	// ********************************************************
	// state register
	// ********************************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_r.st <= lfa_pkg::ST_IDLE;
			s_r.acc <= lfa_pkg::ACC_RST;
			s_r.c <= 1'b0;
			s_r.half_byte_out_flag <= 1'b0;
			s_r.z <= 1'b0;
			s_r.ptr0 <= lfa_pkg::PTR_RST;
			s_r.ptr1 <= lfa_pkg::PTR_RST;
			s_r.cmd <= '0;
			s_r.extra <= 2'h0;
			s_r.last_cyc <= 2'h0;
			s_r.cyc_total <= lfa_pkg::CYC_RST;
			s_r.busy <= 1'b0;
			s_r.haddr <= 12'h000;
			s_r.hwrite <= 1'b0;
			s_r.ph <= 2'h0;
			s_r.hrdata <= 32'h0000_0000;
			s_r.hreadyout <= 1'b1;
			s_r.hresp <= 1'b0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ********************************************************
	// outputs
	// ********************************************************
	assign hrdata = s_r.hrdata;
	assign hreadyout = s_r.hreadyout;
	assign hresp = s_r.hresp;
	assign busy = s_r.busy;
endmodule

/* test/lfa_core_monitor.sv */
// port-level checker for the literal/file alu block
`timescale 1ns/1ps
module lfa_core_monitor (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic busy
);
	// ********************************************************
	// helpers
	// ********************************************************
	logic tk;
	logic nf;
	logic cw;
	assign tk = hsel & htrans[1] & hready & (hsize == 3'h2);
	// file window may stretch the wait while the engine runs
	assign nf = (haddr[11:9] != 3'h1);
	assign cw = tk & hwrite & (haddr[11:2] == 10'h004);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// ********************************************************
	// properties
	// ********************************************************
	a_resp_okay: assert property (hresp == 1'b0)
		else $error("response not okay");
	a_wr_wait: assert property (tk && hwrite && nf |->
		##1 !hreadyout ##1 hreadyout) else $error("write wait wrong");
	a_rd_wait: assert property (tk && !hwrite && nf |->
		##1 !hreadyout [*2] ##1 hreadyout) else $error("read wait wrong");
	a_ready_holds: assert property (hreadyout && !tk |=> hreadyout)
		else $error("ready dropped");
	a_file_bound: assert property (tk && !nf |-> ##[2:8] hreadyout)
		else $error("file access hangs");
	a_cmd_starts: assert property (cw && !busy |-> ##2 busy)
		else $error("command did not start");
	a_busy_cause: assert property ($rose(busy) |-> $past(cw, 2))
		else $error("busy without command");
	a_busy_min: assert property ($rose(busy) |=> busy)
		else $error("instruction too short");
	a_busy_max: assert property ($rose(busy) |-> ##[2:5] !busy)
		else $error("instruction too long");
	cover property (cw);
	cover property ($rose(busy) ##3 busy);
	cover property (tk && !hwrite && !nf);
endmodule

bind lfa_core lfa_core_monitor u_mon (.hclk(hclk), .hresetn(hresetn),
	.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
	.hsize(hsize), .hready(hready), .hreadyout(hreadyout),
	.hresp(hresp), .busy(busy));

/* test/lfa_core_bench.sv */
// self-checking bench for the literal/file alu block
`timescale 1ns/1ps
module lfa_core_bench;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b1;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	logic busy;
	logic [31:0] q;
	int err_count = 0;
	int checks_done = 0;
	always #2.5 hclk = ~hclk;
	lfa_core u_lfa_core (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .busy(busy));
	// ********************************************************
	// bus tasks
	// ********************************************************
	task automatic chk(input string n, input logic [31:0] s,
		input logic [31:0] e);
		checks_done++;
		if (s !== e) begin
			err_count++;
			$display("[FAIL] %s exp %h seen %h", n, e, s);
		end
	endtask
	task automatic xfer(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge hclk);
		haddr <= {20'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask
	task automatic rc(input string n, input logic [11:0] a,
		input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk(n, q, e);
	endtask
	function automatic logic [21:0] cm(logic [2:0] op, logic [7:0] k,
		logic [6:0] f, logic d, logic p, logic pc, logic cd);
		return {cd, pc, op, p, d, f, k};
	endfunction
	// x: stall cycles the instruction should add
	task automatic exe(input logic [21:0] c, input int x);
		int n;
		n = 0;
		xfer(1'b1, 12'h010, {10'h0, c});
		while (busy === 1'b1 && n < 9) begin
			n++;
			@(posedge hclk);
		end
		chk("busy cycles", 32'(n), 32'(2 + x));
		rc("info", 12'h014, 32'(x + 1) << 8);
	endtask
	// operand goes to literal and to file register 5
	task automatic alu(input logic [2:0] op, input logic [7:0] a,
		input logic [7:0] o, input logic d);
		logic [8:0] s;
		logic [4:0] h;
		logic [7:0] r;
		logic [2:0] st;
		s = {1'b0, a} + {1'b0, o};
		h = {1'b0, a[3:0]} + {1'b0, o[3:0]};
		st = 3'b011;
		r = a & o;
		if (op == 3'h1 || op == 3'h3) begin
			r = s[7:0];
			st = {1'b0, h[4], s[8]};
		end
		if (op == 3'h4) begin
			r = {o[7], o[7:1]};
			st[0] = o[0];
		end
		st[2] = (r == 8'h00);
		xfer(1'b1, 12'h000, {24'h0, a});
		xfer(1'b1, 12'h004, 32'h3);
		xfer(1'b1, 12'h214, {24'h0, o});
		exe(cm(op, o, 7'h05, d, 1'b0, 1'b0, 1'b0), 0);
		rc("acc", 12'h000, {24'h0, d ? a : r});
		if (d)
			rc("file", 12'h214, {24'h0, r});
		rc("status", 12'h004, {29'h0, st});
	endtask
	task automatic results();
		if (err_count == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// ********************************************************
	// tests
	// ********************************************************
	initial begin
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		rc("acc", 12'h000, 32'h0);
		rc("ptr0", 12'h008, 32'h0);
		rc("unmapped", 12'h100, 32'h0);
		alu(3'h0, 8'hF0, 8'h0F, 1'b0);
		alu(3'h0, 8'h3C, 8'hFF, 1'b0);
		alu(3'h1, 8'h0F, 8'h01, 1'b0);
		alu(3'h1, 8'hFF, 8'h01, 1'b0);
		alu(3'h1, 8'h80, 8'h80, 1'b0);
		alu(3'h2, 8'hA5, 8'h5A, 1'b1);
		alu(3'h2, 8'hA5, 8'hF0, 1'b0);
		alu(3'h3, 8'h88, 8'h78, 1'b1);
		alu(3'h3, 8'h12, 8'h34, 1'b0);
		alu(3'h4, 8'h81, 8'h81, 1'b0);
		alu(3'h4, 8'h00, 8'h01, 1'b1);
		alu(3'h4, 8'h00, 8'h7E, 1'b0);
		xfer(1'b1, 12'h008, 32'h5);
		xfer(1'b1, 12'h00C, 32'hFFFF);
		xfer(1'b1, 12'h004, 32'h5);
		exe(cm(3'h5, 8'h20, 7'h0, 0, 0, 0, 0), 0);
		rc("ptr0", 12'h008, 32'hFFE5);
		exe(cm(3'h5, 8'h01, 7'h0, 0, 1, 0, 0), 0);
		rc("ptr1", 12'h00C, 32'h0);
		exe(cm(3'h5, 8'hDF, 7'h0, 0, 0, 0, 0), 0);
		rc("ptr0", 12'h008, 32'h4);
		rc("status", 12'h004, 32'h5);
		exe(cm(3'h6, 8'h0, 7'h0, 0, 0, 1, 0), 1);
		exe(cm(3'h7, 8'h0, 7'h0, 0, 0, 0, 1), 1);
		xfer(1'b1, 12'h008, 32'h8010);
		xfer(1'b1, 12'h240, 32'h22);
		xfer(1'b1, 12'h000, 32'h11);
		exe(cm(3'h3, 8'h0, 7'h0, 0, 0, 0, 0), 1);
		rc("acc", 12'h000, 32'h33);
		xfer(1'b1, 12'h018, 32'h0);
		exe(cm(3'h3, 8'h0, 7'h0, 0, 0, 1, 1), 2);
		rc("cycles", 12'h018, 32'h3);
		xfer(1'b1, 12'h008, 32'h0010);
		exe(cm(3'h3, 8'h0, 7'h0, 0, 0, 0, 0), 0);
		rc("acc", 12'h000, 32'h77);
		results();
	end
	initial begin
		#20000;
		err_count++;
		results();
	end
endmodule
